/* File: src/term_map_pkg.sv */
// Shared constants, register map and types of the input terminal function mapper.
package term_map_pkg;

   // ************************************************************
   // Sizes
   // ************************************************************
   localparam int NUM_TERMS = 5;
   localparam int NUM_CODES = 19;
   localparam int CFG_W = 8;
   localparam int APB_AW = 8;
   localparam int APB_DW = 32;
   localparam int APB_SW = 4;
   localparam int SPEED_W = 4;
   localparam int TRIP_CNT_W = 8;

   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [APB_AW-1:0] FUNC_BASE_OFF = 8'h00;
   localparam logic [APB_AW-1:0] POL_BASE_OFF = 8'h14;
   localparam logic [APB_AW-1:0] STATUS_OFF = 8'h28;
   localparam logic [APB_AW-1:0] TRIP_OFF = 8'h2c;
   localparam logic [APB_AW-1:0] WORD_STEP = 8'h04;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int STAT_LEVEL_LSB = 0;
   localparam int STAT_FUNC_LSB = 8;
   localparam int STAT_RUN_BIT = 24;
   localparam int STAT_OFF_BIT = 25;
   localparam int TRIP_FLAG_BIT = 0;
   localparam int TRIP_CODE_LSB = 8;
   localparam int TRIP_COUNT_LSB = 16;

   // ************************************************************
   // Option codes, used as indices of the code hit vector
   // ************************************************************
   localparam int FN_FWD = 0;
   localparam int FN_REV = 1;
   localparam int FN_SPD0 = 2;
   localparam int FN_JOG = 6;
   localparam int FN_DCB = 7;
   localparam int FN_MOT2 = 8;
   localparam int FN_RAMP2 = 9;
   localparam int FN_COAST = 11;
   localparam int FN_TRIP = 12;
   localparam int FN_CLEAR = 18;
   localparam logic [CFG_W-1:0] CODE_CLEAR = 8'h12;

   // ************************************************************
   // Polarity codes and error codes
   // ************************************************************
   localparam logic [CFG_W-1:0] POL_NO = 8'h00;
   localparam logic [CFG_W-1:0] POL_NC = 8'h01;
   localparam logic [CFG_W-1:0] ERR_NONE = 8'h00;
   localparam logic [CFG_W-1:0] ERR_OUTSIDE_TRIP = 8'h0c;

   // ************************************************************
   // Types and reset values
   // ************************************************************
   typedef logic [NUM_TERMS-1:0][CFG_W-1:0] cfg_array_t;

   localparam cfg_array_t FUNC_DEF_EU = {8'h12, 8'h03, 8'h02, 8'h01, 8'h00};
   localparam cfg_array_t FUNC_DEF_US = {8'h09, 8'h0d, 8'h10, 8'h01, 8'h00};
   localparam cfg_array_t POL_DEF_EU = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam cfg_array_t POL_DEF_US = {8'h00, 8'h01, 8'h00, 8'h00, 8'h00};

   typedef struct packed {
      logic run_forward;
      logic run_reverse;
      logic [SPEED_W-1:0] speed_index;
      logic jog_run;
      logic dc_brake_request;
      logic second_motor_select;
      logic second_ramp_select;
      logic coast_stop;
      logic trip_clear;
   } func_bus_t;

   localparam func_bus_t FUNC_IDLE = '0;

endpackage

/* File: src/term_function_decode.sv */
// One terminal: polarity conditioning and decode of its option code.
`timescale 1ns/1ps

module term_function_decode
   import term_map_pkg::*;
(
   input wire logic level_in,
   input wire logic [term_map_pkg::CFG_W-1:0] func_sel_in,
   input wire logic [term_map_pkg::CFG_W-1:0] polarity_in,
   output logic active_out,
   output logic [term_map_pkg::NUM_CODES-1:0] code_hit_out
);

   // ************************************************************
   // Polarity
   // ************************************************************
   wire logic invert;

   assign invert = (polarity_in == POL_NC);
   assign active_out = level_in ^ invert;

   // ************************************************************
   // Code decode
   // ************************************************************
   // Only codes below the vector width can hit; others drive nothing.
   for (genvar c = 0; c < NUM_CODES; c++) begin : g_code
      assign code_hit_out[c] = active_out && (func_sel_in == CFG_W'(c));
   end

endmodule // term_function_decode

/* File: src/input_terminal_function_mapper.sv */
// Input terminal function mapper with APB configuration registers.
`timescale 1ns/1ps

// Operation
// - Each of five terminals has its own option code register.
// - Polarity code 00 passes the level, code 01 inverts it.
// - Reset function code together with inverted polarity is refused.
// - Polarity resets normal on all terminals, terminal four inverted in US variant.
// - Function codes reset to the variant's default set.
// - Active forward input runs forward, otherwise stop.
// - Active reverse input runs reverse, otherwise stop.
// - Codes 02 to 05 give speed index bits 0 to 3.
// - Active jog input runs at jog frequency, otherwise stop.
// - Active brake input requests DC braking during deceleration.
// - Active input selects the second motor parameter set.
// - Active input selects second-stage ramps.
// - Active input turns motor output off to coast.
// - Rising edge of trip input latches outside trip with code E12.
// - Trips stay latched and counted until a reset is applied.
// - Terminals sharing a code are combined by OR.
// - Active reset input clears trip, turns output off, asserts power-up reset.
module input_terminal_function_mapper
   import term_map_pkg::*;
#(
   parameter bit VARIANT_US = 1'b0
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [term_map_pkg::APB_AW-1:0] paddr_in,
   input wire logic [term_map_pkg::APB_DW-1:0] pwdata_in,
   input wire logic [term_map_pkg::APB_SW-1:0] pstrb_in,
   output logic [term_map_pkg::APB_DW-1:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic [term_map_pkg::NUM_TERMS-1:0] terminal_level_in,
   output term_map_pkg::func_bus_t func_out,
   output logic run_mode_out,
   output logic motor_output_off_out,
   output logic powerup_reset_out,
   output logic outside_fault_trip_out,
   output logic [term_map_pkg::CFG_W-1:0] trip_error_code_out
);

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam cfg_array_t FUNC_DEF = VARIANT_US ? FUNC_DEF_US : FUNC_DEF_EU;
   localparam cfg_array_t POL_DEF = VARIANT_US ? POL_DEF_US : POL_DEF_EU;
   localparam logic [TRIP_CNT_W-1:0] TRIP_CNT_MAX = '1;

   // ************************************************************
   // Storage
   // ************************************************************
   cfg_array_t func_sel_q;
   cfg_array_t func_sel_d;
   cfg_array_t polarity_q;
   cfg_array_t polarity_d;
   func_bus_t func_q;
   func_bus_t func_d;
   logic run_mode_q;
   logic run_mode_d;
   logic motor_off_q;
   logic motor_off_d;
   logic trip_q;
   logic trip_d;
   logic [CFG_W-1:0] trip_code_q;
   logic [CFG_W-1:0] trip_code_d;
   logic [TRIP_CNT_W-1:0] trip_cnt_q;
   logic [TRIP_CNT_W-1:0] trip_cnt_d;
   // Last cycle's trip input level, kept for the rising-edge detector.
   logic ext_prev_q;
   logic [APB_DW-1:0] prdata_q;
   logic [APB_DW-1:0] prdata_d;

   // ************************************************************
   // Per-terminal decode and address match
   // ************************************************************
   logic [NUM_TERMS-1:0][NUM_CODES-1:0] code_hit;
   logic [NUM_TERMS-1:0] term_active;
   logic [NUM_TERMS-1:0] func_addr_hit;
   logic [NUM_TERMS-1:0] pol_addr_hit;

   // Each terminal yields one hit vector and owns one word in each register bank.
   for (genvar t = 0; t < NUM_TERMS; t++) begin : g_term
      localparam logic [APB_AW-1:0] STEP_OFF = APB_AW'(t) * WORD_STEP;

      term_function_decode u_decode (
         .level_in(terminal_level_in[t]),
         .func_sel_in(func_sel_q[t]),
         .polarity_in(polarity_q[t]),
         .active_out(term_active[t]),
         .code_hit_out(code_hit[t])
      );

      assign func_addr_hit[t] = (paddr_in == FUNC_BASE_OFF + STEP_OFF);
      assign pol_addr_hit[t] = (paddr_in == POL_BASE_OFF + STEP_OFF);
   end

   // ************************************************************
   // Combine terminals sharing a code
   // ************************************************************
   logic [NUM_CODES-1:0] any_hit;

   always_comb begin
      any_hit = '0;
      for (int t = 0; t < NUM_TERMS; t++) begin
         any_hit = any_hit | code_hit[t];
      end
   end

   // ************************************************************
   // Function signals
   // ************************************************************
   wire logic fwd_cmd;
   wire logic rev_cmd;
   wire logic jog_cmd;
   wire logic clear_cmd;
   wire logic run_block;
   wire logic ext_now;
   wire logic ext_rise;

   assign clear_cmd = any_hit[FN_CLEAR];
   // A latched trip or a pending clear holds every run command off.
   assign run_block = trip_q | clear_cmd;
   // Forward and reverse together mean stop.
   assign fwd_cmd = any_hit[FN_FWD] & ~any_hit[FN_REV] & ~run_block;
   assign rev_cmd = any_hit[FN_REV] & ~any_hit[FN_FWD] & ~run_block;
   // A run command takes precedence over jog.
   assign jog_cmd = any_hit[FN_JOG] & ~any_hit[FN_FWD] & ~any_hit[FN_REV] & ~run_block;
   assign ext_now = any_hit[FN_TRIP];
   // The previous level resets low, so a trip input already active at release counts as an edge.
   assign ext_rise = ext_now & ~ext_prev_q;

   always_comb begin
      func_d = FUNC_IDLE;
      func_d.run_forward = fwd_cmd;
      func_d.run_reverse = rev_cmd;
      // Codes 02 to 05 land on index bits 0 to 3 in order.
      func_d.speed_index = any_hit[FN_SPD0 +: SPEED_W];
      func_d.jog_run = jog_cmd;
      func_d.dc_brake_request = any_hit[FN_DCB];
      func_d.second_motor_select = any_hit[FN_MOT2];
      func_d.second_ramp_select = any_hit[FN_RAMP2];
      func_d.coast_stop = any_hit[FN_COAST];
      func_d.trip_clear = clear_cmd;
   end

   assign run_mode_d = fwd_cmd | rev_cmd | jog_cmd;
   // A latched trip keeps the output off until a clear arrives.
   assign motor_off_d = any_hit[FN_COAST] | clear_cmd | trip_q;

   // ************************************************************
   // Trip latch and history
   // ************************************************************
   // A new edge in the same cycle as a clear keeps the trip set.
   always_comb begin
      trip_d = trip_q;
      trip_code_d = trip_code_q;
      if (ext_rise) begin
         trip_d = 1'b1;
         trip_code_d = ERR_OUTSIDE_TRIP;
      end else if (clear_cmd) begin
         trip_d = 1'b0;
         trip_code_d = ERR_NONE;
      end
   end

   // The count is history: only the system reset clears it.
   assign trip_cnt_d = (ext_rise && trip_cnt_q != TRIP_CNT_MAX) ? trip_cnt_q + 1'b1 : trip_cnt_q;

   // ************************************************************
   // APB decode
   // ************************************************************
   wire logic setup_phase;
   wire logic access_phase;
   wire logic cfg_hit;
   wire logic status_hit;
   wire logic trip_hit;
   wire logic mapped;
   wire logic lane0;
   wire logic [CFG_W-1:0] wr_byte;
   wire logic wr_bad_value;
   wire logic wr_locked;
   wire logic wr_err;
   wire logic rd_err;
   wire logic wr_go;
   logic [CFG_W-1:0] addr_func;
   logic [CFG_W-1:0] addr_pol;

   assign setup_phase = psel_in & ~penable_in;
   assign access_phase = psel_in & penable_in;
   assign cfg_hit = |func_addr_hit | |pol_addr_hit;
   assign status_hit = (paddr_in == STATUS_OFF);
   assign trip_hit = (paddr_in == TRIP_OFF);
   assign mapped = cfg_hit | status_hit | trip_hit;
   assign lane0 = pstrb_in[0];
   assign wr_byte = pwdata_in[CFG_W-1:0];

   // Current settings of the addressed terminal.
   always_comb begin
      addr_func = '0;
      addr_pol = '0;
      for (int t = 0; t < NUM_TERMS; t++) begin
         if (func_addr_hit[t] || pol_addr_hit[t]) begin
            addr_func = func_sel_q[t];
            addr_pol = polarity_q[t];
         end
      end
   end

   // Polarity holds only two codes; reset function never pairs with inversion.
   assign wr_bad_value = (|pol_addr_hit && wr_byte != POL_NO && wr_byte != POL_NC)
      || (|pol_addr_hit && wr_byte == POL_NC && addr_func == CODE_CLEAR)
      || (|func_addr_hit && wr_byte == CODE_CLEAR && addr_pol == POL_NC);
   // Settings are frozen while the drive runs, so no write can retarget a live input.
   assign wr_locked = cfg_hit & run_mode_q;
   assign wr_err = ~mapped | status_hit | trip_hit | (lane0 & (wr_bad_value | wr_locked));
   assign rd_err = ~mapped;

   // Every register answers at once, so the access phase never stretches.
   assign pready_out = 1'b1;
   assign pslverr_out = access_phase & (pwrite_in ? wr_err : rd_err);
   // Only byte lane 0 carries a setting; a write without it stores nothing.
   assign wr_go = access_phase & pwrite_in & pready_out & ~wr_err & lane0;

   // ************************************************************
   // Register writes
   // ************************************************************
   always_comb begin
      func_sel_d = func_sel_q;
      polarity_d = polarity_q;
      for (int t = 0; t < NUM_TERMS; t++) begin
         if (wr_go && func_addr_hit[t]) begin
            func_sel_d[t] = wr_byte;
         end
         if (wr_go && pol_addr_hit[t]) begin
            polarity_d[t] = wr_byte;
         end
      end
   end

   // ************************************************************
   // Read data, sampled in the setup cycle
   // ************************************************************
   logic [APB_DW-1:0] status_word;
   logic [APB_DW-1:0] trip_word;

   always_comb begin
      status_word = '0;
      status_word[STAT_LEVEL_LSB +: NUM_TERMS] = term_active;
      status_word[STAT_FUNC_LSB +: $bits(func_bus_t)] = func_q;
      status_word[STAT_RUN_BIT] = run_mode_q;
      status_word[STAT_OFF_BIT] = motor_off_q;
      trip_word = '0;
      trip_word[TRIP_FLAG_BIT] = trip_q;
      trip_word[TRIP_CODE_LSB +: CFG_W] = trip_code_q;
      trip_word[TRIP_COUNT_LSB +: TRIP_CNT_W] = trip_cnt_q;
   end

   // Capturing in the setup cycle lets the access cycle complete with no wait state.
   always_comb begin
      prdata_d = prdata_q;
      if (setup_phase && !pwrite_in) begin
         prdata_d = '0;
         for (int t = 0; t < NUM_TERMS; t++) begin
            if (func_addr_hit[t]) begin
               prdata_d[CFG_W-1:0] = func_sel_q[t];
            end
            if (pol_addr_hit[t]) begin
               prdata_d[CFG_W-1:0] = polarity_q[t];
            end
         end
         if (status_hit) begin
            prdata_d = status_word;
         end
         if (trip_hit) begin
            prdata_d = trip_word;
         end
      end
   end

   // ************************************************************
   // Flip-flops
   // ************************************************************
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         func_sel_q <= FUNC_DEF;
         polarity_q <= POL_DEF;
      end else begin
         func_sel_q <= func_sel_d;
         polarity_q <= polarity_d;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         func_q <= FUNC_IDLE;
         run_mode_q <= 1'b0;
         motor_off_q <= 1'b0;
         ext_prev_q <= 1'b0;
      end else begin
         func_q <= func_d;
         run_mode_q <= run_mode_d;
         motor_off_q <= motor_off_d;
         ext_prev_q <= ext_now;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         trip_q <= 1'b0;
         trip_code_q <= ERR_NONE;
         trip_cnt_q <= '0;
      end else begin
         trip_q <= trip_d;
         trip_code_q <= trip_code_d;
         trip_cnt_q <= trip_cnt_d;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         prdata_q <= '0;
      end else begin
         prdata_q <= prdata_d;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign prdata_out = prdata_q;
   assign func_out = func_q;
   assign run_mode_out = run_mode_q;
   assign motor_output_off_out = motor_off_q;
   assign powerup_reset_out = func_q.trip_clear;
   assign outside_fault_trip_out = trip_q;
   assign trip_error_code_out = trip_code_q;

endmodule // input_terminal_function_mapper

/* File: test/term_map_properties.sv */
// Port assertions for the input terminal function mapper.
`timescale 1ns/1ps
module term_map_checker
   import term_map_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic pslverr_out,
   input wire term_map_pkg::func_bus_t func_out,
   input wire logic run_mode_out,
   input wire logic motor_output_off_out,
   input wire logic powerup_reset_out,
   input wire logic outside_fault_trip_out,
   input wire logic [term_map_pkg::CFG_W-1:0] trip_error_code_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence trip_set_s;
      !outside_fault_trip_out ##1 outside_fault_trip_out;
   endsequence
   sequence wr_access_s;
      psel_in && penable_in && pwrite_in;
   endsequence
   reset_follows_a: assert property (powerup_reset_out == func_out.trip_clear)
      else $error("reset out differs");
   clear_stops_a: assert property (func_out.trip_clear |-> motor_output_off_out)
      else $error("clear left output on");
   coast_stops_a: assert property (func_out.coast_stop |-> motor_output_off_out)
      else $error("coast left output on");
   run_needs_cmd_a: assert property (!(func_out.run_forward || func_out.run_reverse || func_out.jog_run) |-> !run_mode_out)
      else $error("run without command");
   trip_code_a: assert property (trip_set_s |-> trip_error_code_out == ERR_OUTSIDE_TRIP)
      else $error("trip code wrong");
   code_idle_a: assert property (!outside_fault_trip_out |-> trip_error_code_out == ERR_NONE)
      else $error("code without trip");
   trip_hold_a: assert property ($fell(outside_fault_trip_out) |-> func_out.trip_clear)
      else $error("trip dropped without clear");
   err_in_access_a: assert property (pslverr_out |-> psel_in && penable_in)
      else $error("error outside access");
   lock_in_run_a: assert property ((wr_access_s ##0 run_mode_out) |-> pslverr_out)
      else $error("write taken in run");
endmodule // term_map_checker

bind input_terminal_function_mapper term_map_checker term_map_checker_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .pslverr_out(pslverr_out), .func_out(func_out),
   .run_mode_out(run_mode_out), .motor_output_off_out(motor_output_off_out), .powerup_reset_out(powerup_reset_out),
   .outside_fault_trip_out(outside_fault_trip_out), .trip_error_code_out(trip_error_code_out));

/* File: test/contact_bank_model.sv */
// Behavioural bank of five contacts with a selectable settling lag.
`timescale 1ns/1ps
module contact_bank_model (
   input wire logic clk_in,
   input wire logic [4:0] close_in,
   input wire logic [1:0] lag_in,
   output logic [4:0] level_out
);
   logic [4:0] hist_q [3];
   always @(posedge clk_in) begin
      hist_q[0] <= close_in;
      hist_q[1] <= hist_q[0];
      hist_q[2] <= hist_q[1];
   end
   // A slow contact shows its new state only after its lag has run out.
   assign level_out = (lag_in == 2'd0) ? close_in : hist_q[lag_in - 2'd1];
endmodule // contact_bank_model

/* File: test/input_terminal_function_mapper_tb_top.sv */
// Self-checking bench for the input terminal function mapper.
`timescale 1ns/1ps
module input_terminal_function_mapper_tb_top;
   import term_map_pkg::*;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, go = 1'b0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic [31:0] prdata_us;
   logic [7:0] us_def [10] = '{8'h00, 8'h01, 8'h10, 8'h0d, 8'h09, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
   logic [3:0] pstrb = 4'hf;
   logic pready, pslverr, run_m, m_off, pwr_rst, trip, m_trip, m_prev;
   logic [7:0] tcode;
   logic [4:0] close = '0, level;
   logic [1:0] lag = '0;
   func_bus_t fbus, m_bus;
   logic [7:0] m_func [5], m_pol [5];
   int m_cnt, n_fail = 0, n_checks = 0;

   initial forever #25 clk_in = ~clk_in;

   contact_bank_model contact_bank_model_inst (.clk_in(clk_in), .close_in(close), .lag_in(lag), .level_out(level));
   input_terminal_function_mapper input_terminal_function_mapper_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .terminal_level_in(level), .func_out(fbus),
      .run_mode_out(run_m), .motor_output_off_out(m_off), .powerup_reset_out(pwr_rst),
      .outside_fault_trip_out(trip), .trip_error_code_out(tcode));
   input_terminal_function_mapper #(.VARIANT_US(1'b1)) input_terminal_function_mapper_us_inst (.clk_in(clk_in),
      .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
      .pstrb_in(pstrb), .prdata_out(prdata_us), .pready_out(), .pslverr_out(), .terminal_level_in(level),
      .func_out(), .run_mode_out(), .motor_output_off_out(), .powerup_reset_out(), .outside_fault_trip_out(),
      .trip_error_code_out());

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      if (n_fail == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ************************************************************
   // Reference model, advanced on every rising clock edge
   // ************************************************************
   function automatic logic [18:0] hits();
      hits = '0;
      for (int i = 0; i < 5; i++) begin
         if (level[i] ^ m_pol[i][0]) hits[m_func[i]] = 1'b1;
      end
   endfunction

   always @(posedge clk_in) begin
      logic [18:0] h;
      logic blk;
      h = hits();
      blk = m_trip | h[18];
      if (!rst_n_in) begin
         m_bus <= FUNC_IDLE;
         m_trip <= 1'b0;
         m_prev <= 1'b0;
         m_cnt <= 0;
         m_func <= '{8'h00, 8'h01, 8'h02, 8'h03, 8'h12};
         m_pol <= '{default: 8'h00};
      end else begin
         // Opposing run commands, a trip or a clear leave the drive stopped; jog yields to a run.
         m_bus <= {h[0] & ~h[1] & ~blk, h[1] & ~h[0] & ~blk, h[5:2], h[6] & ~h[0] & ~h[1] & ~blk, h[7], h[8], h[9],
            h[11], h[18]};
         m_prev <= h[12];
         if (h[12] && !m_prev) begin
            m_trip <= 1'b1;
            if (m_cnt < 255) m_cnt <= m_cnt + 1;
         end else if (h[18]) begin
            m_trip <= 1'b0;
         end
      end
   end

   always @(negedge clk_in) begin
      if (go) chk({fbus, trip, tcode}, {m_bus, m_trip, m_trip ? ERR_OUTSIDE_TRIP : ERR_NONE});
   end

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int k;
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      pen <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_in);
         k++;
      end while (pready !== 1'b1 && k < 20);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      if (pready !== 1'b1) begin
         n_fail++;
         print_verdict();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit lock = 1'b0);
      logic [31:0] r;
      logic e;
      bit x;
      int i;
      i = a / 4;
      x = lock || i > 9 || (i > 4 && (d > 1 || (d == 1 && m_func[i-5] == 8'h12)))
          || (i < 5 && d == 8'h12 && m_pol[i] == 8'h01);
      apb(1'b1, a, {24'h0, d}, r, e);
      chk(e, x);
      if (!x && pstrb[0]) begin
         if (i < 5) m_func[i] <= d;
         else m_pol[i-5] <= d;
      end
      @(posedge clk_in);
   endtask

   task automatic rd(input logic [7:0] a);
      logic [31:0] r, x;
      logic e;
      int i;
      i = a / 4;
      apb(1'b0, a, 32'h0, r, e);
      x = 32'h0;
      if (i < 5) x = m_func[i];
      else if (i < 10) x = m_pol[i-5];
      else if (i == 10) x = {6'h0, m_trip, 1'b0, 4'h0, m_bus, 8'h0};
      else if (i == 11) x = {8'h0, m_cnt[7:0], m_trip ? ERR_OUTSIDE_TRIP : ERR_NONE, 7'h0, m_trip};
      chk(r, x);
      chk(e, i > 11);
      @(posedge clk_in);
   endtask

   task automatic idle();
      for (int i = 0; i < 5; i++) close[i] <= m_pol[i][0];
      repeat (lag + 4) @(posedge clk_in);
   endtask

   initial begin
      void'($urandom(82));
      @(posedge clk_in);
      go = 1'b1;
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(posedge clk_in);
      for (int i = 0; i < 12; i++) begin
         rd(8'(i * 4));
         if (i < 10) chk(prdata_us, {24'h0, us_def[i]});
      end
      rd(8'h30);
      wr(8'h28, 8'h01);
      wr(8'h24, 8'h01);
      pstrb <= 4'he;
      wr(8'h00, 8'h07);
      pstrb <= 4'hf;
      rd(8'h00);
      wr(8'h08, 8'h0c);
      repeat (2) begin
         close[2] <= 1'b1;
         repeat (3) @(posedge clk_in);
         close[2] <= 1'b0;
         repeat (3) @(posedge clk_in);
         rd(8'h2c);
      end
      close[4] <= 1'b1;
      repeat (3) @(posedge clk_in);
      chk({m_off, pwr_rst}, 2'b11);
      close[4] <= 1'b0;
      repeat (3) @(posedge clk_in);
      rd(8'h2c);
      wr(8'h0c, 8'h0b);
      for (int t = 0; t < 3; t++) begin
         if (t == 2) wr(8'h04, 8'h06);
         close[t > 0] <= 1'b1;
         repeat (3) @(posedge clk_in);
         chk(run_m, 1'b1);
         wr(8'h10, 8'h07, 1'b1);
         close[t > 0] <= 1'b0;
         repeat (3) @(posedge clk_in);
         chk(run_m, 1'b0);
      end
      close[3] <= 1'b1;
      repeat (3) @(posedge clk_in);
      chk(m_off, 1'b1);
      for (int it = 0; it < 40; it++) begin
         idle();
         for (int i = 0; i < 5; i++) begin
            wr(8'(i * 4), 8'((it * 5 + i) % 19));
            wr(8'(20 + i * 4), 8'($urandom % 2));
            idle();
         end
         rd(8'h28);
         lag <= 2'($urandom % 4);
         repeat (16) begin
            close <= 5'($urandom);
            @(posedge clk_in);
         end
      end
      rst_n_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(posedge clk_in);
      rd(8'h2c);
      rd(8'h10);
      print_verdict();
   end

   initial begin
      #5000000;
      n_fail++;
      print_verdict();
   end
endmodule // input_terminal_function_mapper_tb_top
